// *** core/rac_access_if.sv ***
/*
 address-phase access attributes shared by the checker and its slices.
 assumes one driver (the top) and many readers (the slices).
*/
`timescale 1ns/10ps
`include "rac_map.svh"
interface rac_access_if #(parameter int NMASTER = 4);
   logic [`RAC_ADDR_MSB:0] addr;
   logic [$clog2(NMASTER)-1:0] master;
   logic write;
   logic data_access;
   logic supervisor;
   logic [`RAC_PID_W-1:0] pid;
   logic pid_present;
   modport src (output addr, master, write, data_access, supervisor, pid, pid_present);
   modport slice (input addr, master, write, data_access, supervisor, pid, pid_present);
endinterface

// *** core/rac_checker.sv ***
/*
 region access checker for one or more monitored ahb slave ports.
 assumes masters keep address-phase signals stable while hready is low,
 and that the slave's own response is muxed here with the error response.
*/
// Behaviour
// - one slice per port and descriptor pair
// - hit needs address in range, valid set
// - master picks pid enable; masked pid compare
// - masters without pid always pid-match
// - slice hit_n is inverse of both terms
// - permissions chosen by master and hprot[1]
// - cpu: fetch needs x, read r, write w
// - non-cpu: read needs r, write needs w
// - not-allowed and error-detail outputs per slice
// - and of not-allowed terminates with error
// - no valid hit faults while enabled
// - any granting overlapping region allows access
// - enable clear after reset, then pass all
// - eight-bit pid and mask, set ignores bit
// - supervisor codes rwx, rx, rw, user
// - word 0-2 clears valid, word 3 loads it from bit 31; DESC_ALT keeps it
`timescale 1ns/10ps
`include "rac_map.svh"
module rac_checker #(
   parameter int NPORT = 2,
   parameter int NREGION = 8,
   parameter int NMASTER = 4,
   parameter logic [NMASTER-1:0] CPU_MASK = 4'h3,
   parameter logic [NMASTER-1:0] PID_MASTERS = 4'h3
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // control
   input wire logic ENABLE,
   // descriptor writes
   input wire logic DESC_WR,
   input wire logic [$clog2(NREGION)-1:0] DESC_REGION,
   input wire logic [1:0] DESC_WORD,
   input wire logic DESC_ALT,
   input wire logic [31:0] DESC_WDATA,
   // process identifiers per master
   input wire logic [NMASTER*`RAC_PID_W-1:0] MASTER_PID,
   // ahb master side per port
   input wire logic [NPORT*32-1:0] HADDR,
   input wire logic [NPORT*2-1:0] HTRANS,
   input wire logic [NPORT-1:0] HWRITE,
   input wire logic [NPORT*4-1:0] HPROT,
   input wire logic [NPORT*$clog2(NMASTER)-1:0] HMASTER,
   input wire logic [NPORT-1:0] HREADY,
   // slave response per port
   input wire logic [NPORT-1:0] S_HREADYOUT,
   input wire logic [NPORT-1:0] S_HRESP,
   // gated transfer toward slave and response toward master
   output logic [NPORT*2-1:0] S_HTRANS,
   output logic [NPORT-1:0] M_HREADYOUT,
   output logic [NPORT-1:0] M_HRESP,
   // fault capture
   output logic [NPORT-1:0] FAULT,
   output logic [NPORT*NREGION-1:0] ERROR_DETAIL
);
   localparam int MW = $clog2(NMASTER);
   logic [NREGION-1:0][`RAC_ADDR_MSB:0] srt;
   logic [NREGION-1:0][`RAC_ADDR_MSB:0] ends;
   logic [NREGION-1:0][31:0] accw;
   logic [NREGION-1:0][`RAC_PID_W-1:0] pidv;
   logic [NREGION-1:0][`RAC_PID_W-1:0] pmask;
   logic [NREGION-1:0] vld;
   logic enable_ff;

   rac_descriptors #(.NREGION(NREGION), .NMASTER(NMASTER)) u_desc (
      .clk(CLK),
      .resetn(RESETN),
      .wr_en(DESC_WR),
      .wr_region(DESC_REGION),
      .wr_word(DESC_WORD),
      .wr_alt(DESC_ALT),
      .wr_data(DESC_WDATA),
      .srt_ff(srt),
      .end_ff(ends),
      .acc_ff(accw),
      .pid_ff(pidv),
      .mask_ff(pmask),
      .valid_ff(vld)
   );

   // enable registered so all loaded regions switch on together
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         enable_ff <= 1'b0;
      end else begin
         enable_ff <= ENABLE;
      end
   end

   genvar p, r, m;
   generate
      for (p = 0; p < NPORT; p++) begin : g_port
         rac_access_if #(.NMASTER(NMASTER)) acc ();
         logic [NREGION-1:0] na;
         logic [NREGION-1:0] det;
         logic [NMASTER-1:0] pe [NREGION];
         logic [NMASTER*2-1:0] sm [NREGION];
         logic [NMASTER*3-1:0] um [NREGION];
         logic active;
         logic deny;
         rac_pkg::rac_resp_state_type state_ff;
         logic [NREGION-1:0] det_ff;

         assign acc.addr = HADDR[p*32+31 -: `RAC_ADDR_MSB+1];
         assign acc.master = HMASTER[p*MW +: MW];
         assign acc.write = HWRITE[p];
         assign acc.data_access = HPROT[p*4];
         assign acc.supervisor = HPROT[p*4+1];
         assign acc.pid = MASTER_PID[acc.master*`RAC_PID_W +: `RAC_PID_W];
         assign acc.pid_present = PID_MASTERS[acc.master];

         for (r = 0; r < NREGION; r++) begin : g_rgn
            for (m = 0; m < NMASTER; m++) begin : g_m
               assign pe[r][m] = accw[r][m*6+5];
               assign sm[r][m*2 +: 2] = accw[r][m*6+3 +: 2];
               assign um[r][m*3 +: 3] = accw[r][m*6 +: 3];
            end
            rac_slice #(.NMASTER(NMASTER), .CPU_MASK(CPU_MASK)) u_slice (
               .acc(acc.slice),
               .srt_addr(srt[r]),
               .end_addr(ends[r]),
               .valid(vld[r]),
               .pid(pidv[r]),
               .pid_mask(pmask[r]),
               .master_procid_enable(pe[r]),
               .master_supervisor_perms(sm[r]),
               .master_user_perms(um[r]),
               .not_allowed(na[r]),
               .detail(det[r])
            );
         end

         assign active = HREADY[p] && HTRANS[p*2+1];
         // any granting region wins; no hit at all also denies
         assign deny = enable_ff && active && (&na);

         always_ff @(posedge CLK) begin
            if (!RESETN) begin
               state_ff <= rac_pkg::RAC_IDLE;
            end else begin
               case (state_ff)
                  rac_pkg::RAC_IDLE: if (deny) state_ff <= rac_pkg::RAC_ERR1;
                  rac_pkg::RAC_ERR1: state_ff <= rac_pkg::RAC_ERR2;
                  default: state_ff <= deny ? rac_pkg::RAC_ERR1 : rac_pkg::RAC_IDLE;
               endcase
            end
         end

         always_ff @(posedge CLK) begin
            if (!RESETN) begin
               det_ff <= '0;
            end else if (deny) begin
               det_ff <= det;
            end
         end

         // denied transfer is turned to idle so the slave never sees it
         assign S_HTRANS[p*2 +: 2] = deny ? 2'b00 : HTRANS[p*2 +: 2];
         always_comb begin
            M_HREADYOUT[p] = S_HREADYOUT[p];
            M_HRESP[p] = S_HRESP[p];
            if (state_ff == rac_pkg::RAC_ERR1) begin
               M_HREADYOUT[p] = 1'b0;
               M_HRESP[p] = `RAC_HRESP_ERROR;
            end else if (state_ff == rac_pkg::RAC_ERR2) begin
               M_HREADYOUT[p] = 1'b1;
               M_HRESP[p] = `RAC_HRESP_ERROR;
            end
         end
         assign FAULT[p] = (state_ff == rac_pkg::RAC_ERR1);
         assign ERROR_DETAIL[p*NREGION +: NREGION] = det_ff;
      end
   endgenerate
endmodule

// *** core/rac_descriptors.sv ***
/*
 region descriptor store with the valid-bit upkeep on word writes.
 assumes one word write per cycle; fields laid out in word 2 as packed
 per-master {pe, sm[1:0], um[2:0]} from master 0 upward.
*/
`timescale 1ns/10ps
`include "rac_map.svh"
module rac_descriptors #(
   parameter int NREGION = 8,
   parameter int NMASTER = 4
) (
   input wire logic clk,
   input wire logic resetn,
   // word write
   input wire logic wr_en,
   input wire logic [$clog2(NREGION)-1:0] wr_region,
   input wire logic [1:0] wr_word,
   input wire logic wr_alt,
   input wire logic [31:0] wr_data,
   // descriptor contents
   output logic [NREGION-1:0][`RAC_ADDR_MSB:0] srt_ff,
   output logic [NREGION-1:0][`RAC_ADDR_MSB:0] end_ff,
   output logic [NREGION-1:0][31:0] acc_ff,
   output logic [NREGION-1:0][`RAC_PID_W-1:0] pid_ff,
   output logic [NREGION-1:0][`RAC_PID_W-1:0] mask_ff,
   output logic [NREGION-1:0] valid_ff
);
   always_ff @(posedge clk) begin
      if (!resetn) begin
         srt_ff <= '0;
         end_ff <= '0;
         acc_ff <= '0;
         pid_ff <= '0;
         mask_ff <= '0;
      end else if (wr_en) begin
         case (wr_word)
            `RAC_WORD_SRT: srt_ff[wr_region] <= wr_data[31 -: `RAC_ADDR_MSB+1];
            `RAC_WORD_END: end_ff[wr_region] <= wr_data[31 -: `RAC_ADDR_MSB+1];
            `RAC_WORD_ACC: acc_ff[wr_region] <= wr_data;
            default: begin
               pid_ff[wr_region] <= wr_data[31 -: `RAC_PID_W];
               mask_ff[wr_region] <= wr_data[23 -: `RAC_PID_W];
            end
         endcase
      end
   end

   // alternate access-word view leaves valid alone
   always_ff @(posedge clk) begin
      if (!resetn) begin
         valid_ff <= '0;
      end else if (wr_en && !wr_alt) begin
         if (wr_word == `RAC_WORD_PID) begin
            valid_ff[wr_region] <= wr_data[`RAC_VLD_BIT];
         end else begin
            valid_ff[wr_region] <= 1'b0;
         end
      end
   end
endmodule

// *** core/rac_map.svh ***
/*
 region access checker constants: field positions, encodings, widths.
 assumes inclusion by bare name from the package and the modules.
*/
`ifndef RAC_MAP_SVH
`define RAC_MAP_SVH
`define RAC_ADDR_MSB 26
`define RAC_PID_W 8
`define RAC_SM_RWX 2'b00
`define RAC_SM_RX 2'b01
`define RAC_SM_RW 2'b10
`define RAC_SM_USER 2'b11
`define RAC_UM_R 2
`define RAC_UM_W 1
`define RAC_UM_X 0
`define RAC_VLD_BIT 31
`define RAC_WORD_SRT 2'b00
`define RAC_WORD_END 2'b01
`define RAC_WORD_ACC 2'b10
`define RAC_WORD_PID 2'b11
`define RAC_HTRANS_NONSEQ 2'b10
`define RAC_HTRANS_SEQ 2'b11
`define RAC_HRESP_OKAY 1'b0
`define RAC_HRESP_ERROR 1'b1
`endif

// *** core/rac_pkg.sv ***
/*
 region access checker types.
 assumes rac_map.svh is on the include path.
*/
`include "rac_map.svh"
package rac_pkg;
   typedef enum logic [1:0] {
      RAC_IDLE = 2'b00,
      RAC_ERR1 = 2'b01,
      RAC_ERR2 = 2'b10
   } rac_resp_state_type;
endpackage

// *** core/rac_slice.sv ***
/*
 one access evaluation slice: region hit and permission violation.
 assumes descriptor fields are held stable by the owner of the descriptor store.
*/
`timescale 1ns/10ps
`include "rac_map.svh"
module rac_slice #(
   parameter int NMASTER = 4,
   parameter logic [NMASTER-1:0] CPU_MASK = 4'h3
) (
   // access
   rac_access_if.slice acc,
   // descriptor
   input wire logic [`RAC_ADDR_MSB:0] srt_addr,
   input wire logic [`RAC_ADDR_MSB:0] end_addr,
   input wire logic valid,
   input wire logic [`RAC_PID_W-1:0] pid,
   input wire logic [`RAC_PID_W-1:0] pid_mask,
   input wire logic [NMASTER-1:0] master_procid_enable,
   input wire logic [NMASTER*2-1:0] master_supervisor_perms,
   input wire logic [NMASTER*3-1:0] master_user_perms,
   // result
   output logic not_allowed,
   output logic detail
);
   logic region_hit;
   logic pid_hit;
   logic hit_n;
   logic [1:0] sm;
   logic [2:0] um;
   logic [2:0] eff;
   logic error;

   // no end-above-start check: software keeps the range sane
   assign region_hit = (acc.addr >= srt_addr) && (acc.addr <= end_addr) && valid;
   // set mask bits drop the matching pid bits from the compare
   assign pid_hit = !acc.pid_present || !master_procid_enable[acc.master] ||
      (((acc.pid ^ pid) & ~pid_mask) == '0);
   assign hit_n = !(region_hit && pid_hit);

   assign sm = master_supervisor_perms[acc.master*2 +: 2];
   assign um = master_user_perms[acc.master*3 +: 3];
   always_comb begin
      eff = um;
      if (acc.supervisor) begin
         case (sm)
            `RAC_SM_RWX: eff = 3'h7;
            `RAC_SM_RX: eff = 3'h5;
            `RAC_SM_RW: eff = 3'h6;
            default: eff = um;
         endcase
      end
   end

   always_comb begin
      if (acc.write) begin
         error = !eff[`RAC_UM_W];
      end else if (CPU_MASK[acc.master] && !acc.data_access) begin
         error = !eff[`RAC_UM_X];
      end else begin
         error = !eff[`RAC_UM_R];
      end
   end

   assign not_allowed = hit_n || error;
   assign detail = !hit_n && error;
endmodule

// *** verif/rac_ahb_master_model.sv ***
/*
 bus master model for the address phase of both monitored ports.
 assumes one transfer at a time, requested by a one-cycle go strobe.
*/
`timescale 1ns/10ps
module rac_ahb_master_model (
   // request from the bench
   input wire logic clk,
   input wire logic go,
   input wire logic port,
   input wire logic [31:0] addr,
   input wire logic wr,
   input wire logic [1:0] prot,
   input wire logic [1:0] mst,
   // bus
   input wire logic [1:0] hready,
   output logic [3:0] htrans,
   output logic [63:0] haddr,
   output logic [1:0] hwrite,
   output logic [7:0] hprot,
   output logic [3:0] hmaster
);
   initial begin
      htrans = '0;
      haddr = '0;
      hwrite = '0;
      hprot = '0;
      hmaster = '0;
   end
   always @(posedge clk) begin
      if (go) begin
         htrans[port*2+:2] <= 2'b10;
         haddr[port*32+:32] <= addr;
         hwrite[port] <= wr;
         hprot[port*4+:4] <= {2'b00, prot};
         hmaster[port*2+:2] <= mst;
      end else if (hready[port]) begin
         // a refused transfer is dropped, never retried
         htrans <= '0;
         // released lines must not keep the last address
         haddr <= ~haddr;
      end
   end
endmodule

// *** verif/rac_checker_bench.sv ***
/*
 self-checking bench: random descriptors, masters, modes and addresses.
 assumes the master model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module rac_checker_bench;
   logic CLK, RESETN, ENABLE, DESC_WR, DESC_ALT, go, port, wr;
   logic [2:0] DESC_REGION;
   logic [1:0] DESC_WORD, prot, mst, HWRITE, HREADY, M_HREADYOUT, M_HRESP, FAULT, pend, S_HRESP;
   logic [3:0] HTRANS, HMASTER, S_HTRANS;
   logic [7:0] HPROT;
   logic [15:0] ERROR_DETAIL;
   logic [31:0] DESC_WDATA, MASTER_PID, addr;
   logic [63:0] HADDR;
   logic [9:0] q[$], ex;
   int seed, err_total, n_tests;
   assign HREADY = M_HREADYOUT;
   rac_checker rac_checker_inst (.CLK(CLK), .RESETN(RESETN), .ENABLE(ENABLE), .DESC_WR(DESC_WR),
      .DESC_REGION(DESC_REGION), .DESC_WORD(DESC_WORD), .DESC_ALT(DESC_ALT), .DESC_WDATA(DESC_WDATA),
      .MASTER_PID(MASTER_PID), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HPROT(HPROT),
      .HMASTER(HMASTER), .HREADY(HREADY), .S_HREADYOUT(2'b11), .S_HRESP(S_HRESP), .S_HTRANS(S_HTRANS),
      .M_HREADYOUT(M_HREADYOUT), .M_HRESP(M_HRESP), .FAULT(FAULT), .ERROR_DETAIL(ERROR_DETAIL));
   rac_ahb_master_model rac_ahb_master_model_inst (.clk(CLK), .go(go), .port(port), .addr(addr), .wr(wr),
      .prot(prot), .mst(mst), .hready(HREADY), .htrans(HTRANS), .haddr(HADDR), .hwrite(HWRITE),
      .hprot(HPROT), .hmaster(HMASTER));
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   task fail(input string s);
      err_total++;
      $display("wrong value at %0t: %s", $time, s);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task wd(input int r, input int w, input logic alt, input logic [31:0] d);
      @(posedge CLK);
      DESC_WR <= 1'b1;
      DESC_REGION <= 3'(r);
      DESC_WORD <= 2'(w);
      DESC_ALT <= alt;
      DESC_WDATA <= d;
      @(posedge CLK);
      DESC_WR <= 1'b0;
   endtask
   // f is one master's {pe, sm, um}; pr is {supervisor, data}
   function automatic logic viol_of(logic [5:0] f, logic [1:0] m, logic [1:0] pr, logic w);
      logic [2:0] p;
      p = f[2:0];
      if (pr[1] && f[4:3] != 2'b11) p = {1'b1, ~f[3], ~f[4]};
      if (w) return !p[1];
      if (m < 2 && !pr[0]) return !p[0];
      return !p[2];
   endfunction
   // one access is outstanding at a time, so the oldest note belongs to it
   always @(negedge CLK) begin
      for (int p = 0; p < 2; p++) begin
         if (pend[p]) begin
            ex = q.pop_front();
            n_tests++;
            if (ex[9] !== 1'(p) || FAULT[p] !== ex[8] || M_HRESP[p] !== ex[8] || M_HREADYOUT[p] !== ~ex[8]) fail("response");
            if (ex[8] && ERROR_DETAIL[p*8+:8] !== ex[7:0]) fail("error detail");
         end
         // the oldest note is the transfer standing in this address phase
         if (HTRANS[p*2+1] && HREADY[p] && q.size() != 0) begin
            n_tests++;
            if (S_HTRANS[p*2+:2] !== (q[0][8] ? 2'h0 : HTRANS[p*2+:2])) fail("gated transfer");
         end
         pend[p] = HTRANS[p*2+1] & HREADY[p];
      end
   end
   initial begin
      #50000;
      fail("watchdog");
      final_report;
   end
   initial begin : main
      logic [26:0] base, a;
      logic [31:0] wv[2][4];
      logic [31:0] pv;
      logic [5:0] f;
      logic [1:0] m, pr;
      logic [2:0] k;
      logic v[2];
      logic w, pt, hit, vi, dn, en;
      logic [7:0] det;
      {RESETN, ENABLE, DESC_WR, DESC_ALT, go, port, wr, prot, mst} = '0;
      {DESC_REGION, DESC_WORD, DESC_WDATA, MASTER_PID, addr, pend, S_HRESP} = '0;
      seed = 32'h1080;
      err_total = 0;
      n_tests = 0;
      repeat (16) @(posedge CLK);
      RESETN <= 1'b1;
      @(posedge CLK);
      @(negedge CLK);
      n_tests++;
      if (ERROR_DETAIL !== '0 || FAULT !== '0) fail("reset state");
      for (int i = 0; i < 60; i++) begin
         en = i >= 10 && i < 50;
         base = {4'h0, 23'($random(seed))};
         for (int r = 0; r < 2; r++) begin
            wv[r][0] = {base + 27'($random(seed) & 3), 5'h00};
            wv[r][1] = {wv[r][0][31:5] + 27'($random(seed) & 3), 5'h00}; // end kept at or above start
            wv[r][2] = $random(seed);
            wv[r][3] = $random(seed) | 32'h80000000;
            for (int j = 0; j < 4; j++) wd(r, j, 1'b0, wv[r][j]);
            k = 3'($random(seed));
            wd(r, k > 2 ? 2 : k, k > 2, wv[r][k > 2 ? 2 : k]);
            v[r] = k > 2; // plain words 0..2 clear valid, the alternate view keeps it
         end
         ENABLE <= en; // descriptors are loaded before checking is switched on
         repeat (2) @(posedge CLK);
         a = base + 27'($random(seed) & 7);
         {pv, m, pr, w, pt} = {$random(seed), 6'($random(seed))};
         dn = 1'b1;
         det = '0;
         for (int r = 0; r < 2; r++) begin
            hit = v[r] && a >= wv[r][0][31:5] && a <= wv[r][1][31:5];
            f = wv[r][2][m*6+:6];
            if (m < 2 && f[5] && ((pv[m*8+:8] ^ wv[r][3][31:24]) & ~wv[r][3][23:16]) != 0) hit = 1'b0;
            vi = viol_of(f, m, pr, w);
            det[r] = hit & vi;
            if (hit && !vi) dn = 1'b0;
         end
         @(posedge CLK);
         q.push_back({pt, dn & en, det});
         go <= 1'b1;
         port <= pt;
         addr <= {a, 5'($random(seed))};
         wr <= w;
         prot <= pr;
         mst <= m;
         MASTER_PID <= pv;
         @(posedge CLK);
         go <= 1'b0;
         repeat (2) @(posedge CLK);
         // slave answer outside the error cycles must pass through untouched
         S_HRESP <= 2'($random(seed));
         repeat (2) @(posedge CLK);
         S_HRESP <= 2'h0;
         @(posedge CLK);
         $display("test %0d done", i);
      end
      final_report;
   end
endmodule

// *** verif/rac_prot_checker.sv ***
/*
 concurrent checks on the region access checker top ports.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module rac_prot_checker #(
   parameter int NPORT = 2,
   parameter int NREGION = 8
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic ENABLE,
   input wire logic [NPORT*2-1:0] HTRANS,
   input wire logic [NPORT-1:0] HREADY,
   input wire logic [NPORT-1:0] S_HREADYOUT,
   input wire logic [NPORT-1:0] S_HRESP,
   input wire logic [NPORT*2-1:0] S_HTRANS,
   input wire logic [NPORT-1:0] M_HREADYOUT,
   input wire logic [NPORT-1:0] M_HRESP,
   input wire logic [NPORT-1:0] FAULT,
   input wire logic [NPORT*NREGION-1:0] ERROR_DETAIL
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence taken0;
      HREADY[0] && HTRANS[1];
   endsequence
   sequence err_tail0;
      !M_HREADYOUT[0] && M_HRESP[0] ##1 M_HREADYOUT[0] && M_HRESP[0];
   endsequence
   sequence off2;
      !ENABLE ##1 !ENABLE;
   endsequence
   chk_deny_faults: assert property (taken0 ##0 S_HTRANS[1:0] == 2'b00 |=> err_tail0)
      else $error("denied transfer not error-terminated");
   chk_pass_quiet: assert property (taken0 ##0 S_HTRANS[1:0] == HTRANS[1:0] |=> !FAULT[0] && M_HRESP[0] == S_HRESP[0])
      else $error("forwarded transfer answered with a fault");
   chk_fault_cause: assert property (FAULT[0] |-> $past(HTRANS[1] && HREADY[0] && S_HTRANS[1:0] == 2'b00))
      else $error("fault without a denied transfer");
   chk_off_pass: assert property (off2 |-> S_HTRANS == HTRANS)
      else $error("transfer gated while checking is off");
   chk_slave_follow: assert property (!FAULT[0] && !$past(FAULT[0]) |-> M_HREADYOUT[0] == S_HREADYOUT[0] && M_HRESP[0] == S_HRESP[0])
      else $error("slave response not passed through");
   chk_detail_hold: assert property (!(|FAULT) |-> $stable(ERROR_DETAIL))
      else $error("error detail changed without a fault");
   chk_deny_port1: assert property (HREADY[1] && HTRANS[3] && S_HTRANS[3:2] == 2'b00 |=> FAULT[1] ##1 (M_HREADYOUT[1] && M_HRESP[1]))
      else $error("port 1 denial not error-terminated");
   chk_gate_shape: assert property (S_HTRANS[1:0] == HTRANS[1:0] || S_HTRANS[1:0] == 2'b00)
      else $error("forwarded transfer type altered");
endmodule
bind rac_checker rac_prot_checker #(.NPORT(NPORT), .NREGION(NREGION)) rac_prot_checker_inst (
   .CLK(CLK), .RESETN(RESETN), .ENABLE(ENABLE), .HTRANS(HTRANS), .HREADY(HREADY), .S_HREADYOUT(S_HREADYOUT),
   .S_HRESP(S_HRESP), .S_HTRANS(S_HTRANS), .M_HREADYOUT(M_HREADYOUT), .M_HRESP(M_HRESP), .FAULT(FAULT),
   .ERROR_DETAIL(ERROR_DETAIL));
